/* File: bench/orl_diag_checker.sv */
`timescale 1ns/1ps
module orl_diag_checker (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_tlg_vld,
	input wire logic [7:0] i_tlg_data,
	input wire logic [7:0] i_tlg_id,
	input wire logic i_tlg_err,
	input wire logic i_ring_up,
	input wire logic i_cyc_req,
	input wire logic i_diag_rd,
	input wire logic i_diag_tbl,
	input wire logic [6:0] i_diag_addr,
	input wire logic [7:0] i_pd_bits,
	input wire logic o_fwd_vld,
	input wire logic [7:0] o_fwd_data,
	input wire logic o_fwd_err,
	input wire logic o_retx,
	input wire logic [7:0] o_retx_id,
	input wire logic o_cyc_start,
	input wire logic o_diag_ack,
	input wire logic [15:0] o_diag_data,
	input wire logic [4:0] o_pd_bytes
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_bad;
		i_tlg_vld && i_tlg_err;
	endsequence
	sequence s_zero_rd;
		i_diag_rd && (i_diag_tbl ? (!i_ring_up || i_diag_addr > 7'h78) :
			(i_diag_addr > 7'h07 || i_diag_addr < 7'h05));
	endsequence
	a_fwd_copy: assert property (i_tlg_vld |=> o_fwd_vld && o_fwd_data == $past(i_tlg_data)
		&& o_fwd_err == $past(i_tlg_err)) else $error("forward mismatch");
	a_fwd_idle: assert property (!i_tlg_vld |=> !o_fwd_vld) else $error("stray forward");
	a_retx_pulse: assert property (s_bad |=> o_retx && o_retx_id == $past(i_tlg_id))
		else $error("no retransmit");
	a_retx_quiet: assert property (!(i_tlg_vld && i_tlg_err) |=> !o_retx && $stable(o_retx_id))
		else $error("stray retransmit");
	a_ack_pulse: assert property (i_diag_rd |=> o_diag_ack) else $error("no ack");
	a_no_push: assert property (!i_diag_rd |=> !o_diag_ack && $stable(o_diag_data))
		else $error("pushed data");
	a_zero_read: assert property (s_zero_rd |=> o_diag_data == 16'h0000)
		else $error("nonzero read");
	a_cyc_follow: assert property (i_cyc_req |=> o_cyc_start) else $error("no cycle start");
	a_pd_round: assert property (1'b1 |=> o_pd_bytes == (($past(i_pd_bits) == 8'h00) ? 5'h01 :
		5'(({1'b0, $past(i_pd_bits)} + 9'h007) >> 3))) else $error("byte count");
endmodule : orl_diag_checker
bind orl_diag orl_diag_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
	.i_tlg_vld(i_tlg_vld), .i_tlg_data(i_tlg_data), .i_tlg_id(i_tlg_id),
	.i_tlg_err(i_tlg_err), .i_ring_up(i_ring_up), .i_cyc_req(i_cyc_req),
	.i_diag_rd(i_diag_rd), .i_diag_tbl(i_diag_tbl), .i_diag_addr(i_diag_addr),
	.i_pd_bits(i_pd_bits), .o_fwd_vld(o_fwd_vld), .o_fwd_data(o_fwd_data),
	.o_fwd_err(o_fwd_err), .o_retx(o_retx), .o_retx_id(o_retx_id),
	.o_cyc_start(o_cyc_start), .o_diag_ack(o_diag_ack), .o_diag_data(o_diag_data),
	.o_pd_bytes(o_pd_bytes));

/* File: bench/orl_ring_model.sv */
`timescale 1ns/1ps
module orl_ring_model (
	input wire logic i_clk,
	input wire logic i_en,
	input wire logic [1:0] i_mode,
	output logic o_vld,
	output logic [7:0] o_data,
	output logic [7:0] o_id,
	output logic o_err
);
	logic [7:0] seq = 8'h00;
	logic en_s = 1'b0;
	logic [1:0] mode_s = 2'h0;
	initial begin
		o_vld = 1'b0;
		o_data = 8'h00;
		o_id = 8'h00;
		o_err = 1'b0;
	end
	// Mode 0 clean, 1 one faulty in eight, 2 all faulty
	always @(posedge i_clk) begin
		en_s = i_en;
		mode_s = i_mode;
		#1;
		if (en_s) begin
			seq = seq + 8'h01;
			o_data = seq;
			o_id = ~seq;
			o_err = (mode_s == 2'h2) || (mode_s == 2'h1 && seq[2:0] == 3'h0);
		end else begin
			o_data = ~o_data;
			o_id = ~o_id;
			o_err = 1'b0;
		end
		o_vld = en_s;
	end
endmodule : orl_ring_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic tx_en = 1'b0;
	logic [1:0] tx_mode = 2'h0;
	logic i_ring_up = 1'b1;
	logic [6:0] i_last_ok_pos = 7'h05;
	logic i_free_run = 1'b0;
	logic i_cyc_req = 1'b0;
	logic i_mod_wr = 1'b0;
	logic [6:0] i_mod_pos = 7'h00;
	logic [15:0] i_mod_cnt = 16'h0000;
	logic i_diag_rd = 1'b0;
	logic i_diag_tbl = 1'b0;
	logic [6:0] i_diag_addr = 7'h00;
	logic [7:0] i_pd_bits = 8'h00;
	logic i_tlg_vld, i_tlg_err, o_fwd_vld, o_fwd_err, o_retx, o_cyc_start, o_diag_ack;
	logic o_ext_green, o_ext_red, o_run_led, o_err_led;
	logic [7:0] i_tlg_data, i_tlg_id, o_fwd_data, o_retx_id;
	logic [15:0] o_diag_data;
	logic [4:0] o_pd_bytes;
	logic [31:0] lfsr = 32'h94d1_9149;
	logic [15:0] exp_err = 16'h0000;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int g_hi, r_hi, run_hi, e_hi, n;
	always #2 i_clk = ~i_clk;
	orl_ring_model u_ring (.i_clk(i_clk), .i_en(tx_en), .i_mode(tx_mode), .o_vld(i_tlg_vld),
		.o_data(i_tlg_data), .o_id(i_tlg_id), .o_err(i_tlg_err));
	orl_diag #(.BLINK_HALF_CYC(4)) DUT (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_tlg_vld(i_tlg_vld), .i_tlg_data(i_tlg_data), .i_tlg_id(i_tlg_id),
		.i_tlg_err(i_tlg_err), .i_ring_up(i_ring_up), .i_last_ok_pos(i_last_ok_pos),
		.i_free_run(i_free_run), .i_cyc_req(i_cyc_req), .i_mod_wr(i_mod_wr),
		.i_mod_pos(i_mod_pos), .i_mod_cnt(i_mod_cnt), .i_diag_rd(i_diag_rd),
		.i_diag_tbl(i_diag_tbl), .i_diag_addr(i_diag_addr), .i_pd_bits(i_pd_bits),
		.o_fwd_vld(o_fwd_vld), .o_fwd_data(o_fwd_data), .o_fwd_err(o_fwd_err),
		.o_retx(o_retx), .o_retx_id(o_retx_id), .o_cyc_start(o_cyc_start),
		.o_ext_green(o_ext_green), .o_ext_red(o_ext_red), .o_run_led(o_run_led),
		.o_err_led(o_err_led), .o_diag_ack(o_diag_ack), .o_diag_data(o_diag_data),
		.o_pd_bytes(o_pd_bytes));
	// Expected error count, saturating, cleared by power cycle only
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			exp_err <= 16'h0000;
		end else if (i_tlg_vld && i_tlg_err && exp_err != 16'hFFFF) begin
			exp_err <= exp_err + 16'h0001;
		end
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next
	function automatic logic [4:0] pd_exp(input logic [7:0] b);
		if (b < 8'h09) begin
			return 5'h01;
		end
		return 5'(b[7:3]) + 5'(b[2:0] != 3'h0);
	endfunction : pd_exp
	task automatic tick;
		@(posedge i_clk);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd(input logic tbl, input logic [6:0] a, input logic [15:0] exp);
		i_diag_rd = 1'b1;
		i_diag_tbl = tbl;
		i_diag_addr = a;
		tick;
		i_diag_rd = 1'b0;
		chk({15'h0000, o_diag_ack}, 16'h0001);
		chk(o_diag_data, exp);
		tick;
		chk({15'h0000, o_diag_ack}, 16'h0000);
		chk(o_diag_data, exp);
	endtask : rd
	task automatic phase(input logic up, input logic en, input logic [1:0] m);
		i_ring_up = up;
		tx_en = en;
		tx_mode = m;
		repeat (5000) tick;
		g_hi = 0;
		r_hi = 0;
		run_hi = 0;
		e_hi = 0;
		repeat (400) begin
			tick;
			g_hi += int'(o_ext_green === 1'b1);
			r_hi += int'(o_ext_red === 1'b1);
			run_hi += int'(o_run_led === 1'b1);
			e_hi += int'(o_err_led === 1'b1);
		end
		tx_en = 1'b0;
		repeat (2) tick;
	endtask : phase
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		repeat (6) @(posedge i_clk);
		chk({14'h0000, o_ext_green, o_ext_red}, 16'h0001);
		#1;
		i_arst_n = 1'b1;
		for (int k = 0; k < 12; k++) begin
			lfsr = lfsr_next(lfsr);
			i_pd_bits = (k == 0) ? 8'h00 : (k == 1) ? 8'h04 : (k == 2) ? 8'h09 : lfsr[7:0];
			tick;
			chk(16'(o_pd_bytes), 16'(pd_exp(i_pd_bits)));
		end
		i_cyc_req = 1'b1;
		tick;
		i_cyc_req = 1'b0;
		phase(1'b1, 1'b1, 2'h0);
		chk({g_hi == 400, r_hi == 0, e_hi == 0}, 16'h0007);
		chk({run_hi > 0, run_hi < 400}, 16'h0003);
		rd(1'b0, 7'h06, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			lfsr = lfsr_next(lfsr);
			i_mod_pos = lfsr[22:16] % 7'h78;
			i_mod_cnt = lfsr[15:0];
			i_mod_wr = 1'b1;
			tick;
			i_mod_wr = 1'b0;
			rd(1'b1, i_mod_pos, i_mod_cnt);
		end
		phase(1'b1, 1'b1, 2'h1);
		chk({g_hi > 0, g_hi < 400, r_hi > 0, r_hi < 400, e_hi > 0}, 16'h001F);
		rd(1'b0, 7'h05, exp_err);
		rd(1'b0, 7'h06, 16'h00FF);
		rd(1'b0, 7'h07, 16'h00FF);
		phase(1'b1, 1'b1, 2'h2);
		chk({g_hi == 0, r_hi > 0, r_hi < 400}, 16'h0007);
		rd(1'b0, 7'h05, exp_err);
		lfsr = lfsr_next(lfsr);
		i_last_ok_pos = lfsr[6:0];
		phase(1'b0, 1'b0, 2'h0);
		chk({g_hi == 0, r_hi == 400, run_hi == 0, e_hi > 0}, 16'h000F);
		i_mod_wr = 1'b1;
		tick;
		i_mod_wr = 1'b0;
		rd(1'b1, i_mod_pos, 16'h0000);
		i_ring_up = 1'b1;
		rd(1'b1, 7'h7F, 16'h0000);
		rd(1'b0, 7'h09, 16'h0000);
		i_free_run = 1'b1;
		n = 0;
		repeat (2500) begin
			tick;
			n += int'(o_cyc_start === 1'b1);
		end
		chk(16'(n), 16'h0001);
		i_arst_n = 1'b0;
		tick;
		i_arst_n = 1'b1;
		tick;
		rd(1'b0, 7'h05, 16'h0000);
		close_out;
	end
endmodule : testbench

/* File: logic/orl_blink.sv */
`timescale 1ns/1ps
module orl_blink #(
	parameter int HALF_CYC = orl_pkg::BLINK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_en,
	input wire logic [3:0] i_code,
	input wire logic [6:0] i_arg,
	output logic o_led
);
	typedef enum {BL_IDLE, BL_CODE, BL_GAP1, BL_ARG, BL_GAP2} orl_bl_e;

	orl_bl_e state, next_state;
	logic [31:0] cnt, next_cnt;
	logic [6:0] rem, next_rem;
	logic [3:0] gap, next_gap;
	logic led, next_led;
	logic tick;

	// Group of code pulses, pause, group of argument pulses, pause
	always_comb begin
		tick = (cnt == 32'(HALF_CYC - 1));
		next_cnt = tick ? 32'h0000_0000 : cnt + 32'h0000_0001;
		next_state = state;
		next_rem = rem;
		next_gap = gap;
		next_led = led;
		case (state)
			BL_IDLE: begin
				next_led = 1'b0;
				if (i_en && tick && i_code != 4'h0) begin
					next_state = BL_CODE;
					next_rem = {3'h0, i_code};
					next_led = 1'b1;
				end
			end
			BL_CODE, BL_ARG: begin
				if (tick) begin
					if (led) begin
						next_led = 1'b0;
						next_rem = rem - 7'h01;
						if (rem == 7'h01) begin
							next_gap = orl_pkg::BLINK_GAP;
							next_state = (state == BL_CODE) ? BL_GAP1 : BL_GAP2;
						end
					end else begin
						next_led = 1'b1;
					end
				end
			end
			BL_GAP1: begin
				if (tick) begin
					next_gap = gap - 4'h1;
					if (gap == 4'h1) begin
						if (i_arg != 7'h00) begin
							next_state = BL_ARG;
							next_rem = i_arg;
							next_led = 1'b1;
						end else begin
							next_state = BL_IDLE;
						end
					end
				end
			end
			BL_GAP2: begin
				if (tick && gap == 4'h1) begin
					next_state = BL_IDLE;
				end else if (tick) begin
					next_gap = gap - 4'h1;
				end
			end
			default: begin
				next_state = BL_IDLE;
				next_led = 1'b0;
			end
		endcase
		if (!i_en) begin
			next_state = BL_IDLE;
			next_led = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= BL_IDLE;
			cnt <= 32'h0000_0000;
			rem <= 7'h00;
			gap <= 4'h0;
			led <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rem <= next_rem;
			gap <= next_gap;
			led <= next_led;
		end
	end

	assign o_led = led;
endmodule : orl_blink

/* File: logic/orl_diag.sv */
// Contract
// R1: No data received: extension green off, red steadily on.
// R2: Very poor link: extension green off, red blinking.
// R3: Poor link: extension green and red both blinking.
// R4: Valid telegrams without error: green steadily on, red off.
// R5: Run indicator flashes during exchange; error indicator blinks on faulty telegrams.
// R6: Every faulty telegram triggers an automatic retransmission request.
// R7: Detected ring errors accumulate in coupler table position 5.
// R8: Ring error counter cleared only by power cycle, no soft clear.
// R9: Many errors quickly: heavy disturbance, positions 6 and 7 above 200, blink code.
// R10: Broken or heavily disturbed ring: blink last working module position.
// R11: Per-module error table indexed by module chain position.
// R12: Per-module counters come from modules; all zeroed when ring interrupted.
// R13: Host must re-read diagnostics itself; nothing is pushed.
// R14: Free-running mode generates cyclic ring traffic without fieldbus master.
// R15: Telegrams are regenerated and passed on, errors are not corrected.
// R16: Process data narrower than a byte occupies a full padded byte.
// R17: Configuring party lists analog modules first, then digital, in ring order.
// R18: Ring error counters saturate instead of wrapping.
`timescale 1ns/1ps
module orl_diag #(
	parameter int BLINK_HALF_CYC = orl_pkg::BLINK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_tlg_vld,
	input wire logic [7:0] i_tlg_data,
	input wire logic [7:0] i_tlg_id,
	input wire logic i_tlg_err,
	input wire logic i_ring_up,
	input wire logic [6:0] i_last_ok_pos,
	input wire logic i_free_run,
	input wire logic i_cyc_req,
	input wire logic i_mod_wr,
	input wire logic [6:0] i_mod_pos,
	input wire logic [15:0] i_mod_cnt,
	input wire logic i_diag_rd,
	input wire logic i_diag_tbl,
	input wire logic [6:0] i_diag_addr,
	input wire logic [7:0] i_pd_bits,
	output logic o_fwd_vld,
	output logic [7:0] o_fwd_data,
	output logic o_fwd_err,
	output logic o_retx,
	output logic [7:0] o_retx_id,
	output logic o_cyc_start,
	output logic o_ext_green,
	output logic o_ext_red,
	output logic o_run_led,
	output logic o_err_led,
	output logic o_diag_ack,
	output logic [15:0] o_diag_data,
	output logic [4:0] o_pd_bytes
);
	orl_pkg::orl_lnk_e lnk, next_lnk;
	logic [15:0] err_cnt, next_err_cnt;
	logic [15:0] win_cnt, next_win_cnt;
	logic [15:0] win_tlg, next_win_tlg;
	logic [15:0] win_err, next_win_err;
	logic heavy, next_heavy;
	logic err_seen, next_err_seen;
	logic [31:0] tog_cnt, next_tog_cnt;
	logic tog, next_tog;
	logic [3:0] code, next_code;
	logic [6:0] code_arg, next_code_arg;
	logic next_ext_green, next_ext_red, next_run_led, next_err_led;
	logic next_fwd_vld, next_fwd_err, next_retx, next_cyc_start, next_diag_ack;
	logic [7:0] next_fwd_data, next_retx_id;
	logic [15:0] next_diag_data;
	logic [4:0] next_pd_bytes;
	logic [15:0] mod_tbl [0:orl_pkg::MAX_MOD];
	logic [15:0] next_mod_tbl [0:orl_pkg::MAX_MOD];
	logic blink_led;
	logic bad_tlg, win_end;
	logic [15:0] t_sum, e_sum;
	logic [17:0] e_x4;

	orl_blink #(
		.HALF_CYC(BLINK_HALF_CYC)
	) u_blink (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_en(code != 4'h0),
		.i_code(code),
		.i_arg(code_arg),
		.o_led(blink_led)
	);

	// Per-module table: written by the modules, wiped on ring break
	always_comb begin
		for (int i = 0; i <= orl_pkg::MAX_MOD; i++) begin
			next_mod_tbl[i] = mod_tbl[i];
		end
		if (!i_ring_up) begin
			for (int i = 0; i <= orl_pkg::MAX_MOD; i++) begin
				next_mod_tbl[i] = orl_pkg::CNT_RST; // R12
			end
		end else if (i_mod_wr && i_mod_pos <= 7'(orl_pkg::MAX_MOD)) begin
			next_mod_tbl[i_mod_pos] = i_mod_cnt; // R11 R12
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i <= orl_pkg::MAX_MOD; i++) begin
				mod_tbl[i] <= orl_pkg::CNT_RST;
			end
		end else begin
			for (int i = 0; i <= orl_pkg::MAX_MOD; i++) begin
				mod_tbl[i] <= next_mod_tbl[i];
			end
		end
	end

	// Link quality, counters, indicators and read port
	always_comb begin
		bad_tlg = i_tlg_vld && i_tlg_err;
		win_end = (win_cnt == 16'(orl_pkg::WIN_CYC - 1));
		next_win_cnt = win_end ? 16'h0000 : win_cnt + 16'h0001;
		t_sum = orl_pkg::orl_sat_inc(win_tlg, i_tlg_vld);
		e_sum = orl_pkg::orl_sat_inc(win_err, bad_tlg);
		e_x4 = {e_sum, 2'b00};
		next_win_tlg = win_end ? 16'h0000 : t_sum;
		next_win_err = win_end ? 16'h0000 : e_sum;
		next_lnk = lnk;
		next_heavy = heavy;
		next_err_seen = err_seen;
		if (win_end) begin
			if (!i_ring_up || t_sum == 16'h0000) begin
				next_lnk = orl_pkg::LNK_NONE;
			end else if (e_x4 > {2'b00, t_sum}) begin
				next_lnk = orl_pkg::LNK_BAD;
			end else if (e_sum != 16'h0000) begin
				next_lnk = orl_pkg::LNK_POOR;
			end else begin
				next_lnk = orl_pkg::LNK_GOOD;
			end
			next_heavy = (e_sum >= orl_pkg::HEAVY_ERR); // R9
			next_err_seen = (e_sum != 16'h0000);
		end
		next_err_cnt = orl_pkg::orl_sat_inc(err_cnt, bad_tlg); // R7 R8 R18
		next_tog_cnt = tog_cnt + 32'h0000_0001;
		next_tog = tog;
		if (tog_cnt == 32'(BLINK_HALF_CYC - 1)) begin
			next_tog_cnt = 32'h0000_0000;
			next_tog = !tog;
		end
		case (lnk)
			orl_pkg::LNK_NONE: begin
				next_ext_green = 1'b0; // R1
				next_ext_red = 1'b1; // R1
			end
			orl_pkg::LNK_BAD: begin
				next_ext_green = 1'b0; // R2
				next_ext_red = tog; // R2
			end
			orl_pkg::LNK_POOR: begin
				next_ext_green = tog; // R3
				next_ext_red = tog; // R3
			end
			orl_pkg::LNK_GOOD: begin
				next_ext_green = 1'b1; // R4
				next_ext_red = 1'b0; // R4
			end
			default: begin
				next_ext_green = 1'b0;
				next_ext_red = 1'b1;
			end
		endcase
		next_code = 4'h0;
		next_code_arg = 7'h00;
		if (!i_ring_up) begin
			next_code = orl_pkg::CODE_BREAK; // R10
			next_code_arg = i_last_ok_pos; // R10
		end else if (heavy) begin
			next_code = orl_pkg::CODE_HEAVY; // R9 R10
			next_code_arg = i_last_ok_pos; // R10
		end
		next_run_led = (lnk != orl_pkg::LNK_NONE) && tog; // R5
		next_err_led = (code != 4'h0) ? blink_led : (err_seen && tog); // R5
		next_fwd_vld = i_tlg_vld; // R15
		next_fwd_data = i_tlg_data; // R15
		next_fwd_err = i_tlg_err; // R15
		next_retx = bad_tlg; // R6
		next_retx_id = bad_tlg ? i_tlg_id : o_retx_id; // R6
		next_cyc_start = i_cyc_req || (i_free_run && win_end); // R14
		next_diag_ack = i_diag_rd; // R13
		next_diag_data = o_diag_data;
		if (i_diag_rd) begin
			next_diag_data = 16'h0000;
			if (i_diag_tbl) begin
				if (i_ring_up && i_diag_addr <= 7'(orl_pkg::MAX_MOD)) begin // R12
					next_diag_data = mod_tbl[i_diag_addr]; // R11
				end
			end else if (i_diag_addr == orl_pkg::POS_ERR_CNT) begin
				next_diag_data = err_cnt; // R7
			end else if (i_diag_addr == orl_pkg::POS_HEAVY_A ||
				i_diag_addr == orl_pkg::POS_HEAVY_B) begin
				next_diag_data = heavy ? orl_pkg::HEAVY_REPORT : 16'h0000; // R9
			end
		end
		next_pd_bytes = orl_pkg::orl_pd_bytes(i_pd_bits); // R16
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lnk <= orl_pkg::LNK_NONE;
			err_cnt <= orl_pkg::CNT_RST;
			win_cnt <= 16'h0000;
			win_tlg <= 16'h0000;
			win_err <= 16'h0000;
			heavy <= 1'b0;
			err_seen <= 1'b0;
			tog_cnt <= 32'h0000_0000;
			tog <= 1'b0;
			code <= 4'h0;
			code_arg <= 7'h00;
			o_ext_green <= 1'b0;
			o_ext_red <= 1'b1;
			o_run_led <= 1'b0;
			o_err_led <= 1'b0;
			o_fwd_vld <= 1'b0;
			o_fwd_data <= 8'h00;
			o_fwd_err <= 1'b0;
			o_retx <= 1'b0;
			o_retx_id <= 8'h00;
			o_cyc_start <= 1'b0;
			o_diag_ack <= 1'b0;
			o_diag_data <= 16'h0000;
			o_pd_bytes <= 5'h01;
		end else begin
			lnk <= next_lnk;
			err_cnt <= next_err_cnt;
			win_cnt <= next_win_cnt;
			win_tlg <= next_win_tlg;
			win_err <= next_win_err;
			heavy <= next_heavy;
			err_seen <= next_err_seen;
			tog_cnt <= next_tog_cnt;
			tog <= next_tog;
			code <= next_code;
			code_arg <= next_code_arg;
			o_ext_green <= next_ext_green;
			o_ext_red <= next_ext_red;
			o_run_led <= next_run_led;
			o_err_led <= next_err_led;
			o_fwd_vld <= next_fwd_vld;
			o_fwd_data <= next_fwd_data;
			o_fwd_err <= next_fwd_err;
			o_retx <= next_retx;
			o_retx_id <= next_retx_id;
			o_cyc_start <= next_cyc_start;
			o_diag_ack <= next_diag_ack;
			o_diag_data <= next_diag_data;
			o_pd_bytes <= next_pd_bytes;
		end
	end
endmodule : orl_diag

/* File: logic/orl_pkg.sv */
package orl_pkg;
	// Clock rate
	localparam int CLK_MHZ = 250;
	// Quality evaluation window
	localparam int WIN_TIME_US = 10;
	localparam int WIN_CYC = WIN_TIME_US * CLK_MHZ;
	// Indicator blink half period
	localparam int BLINK_TIME_MS = 100;
	localparam int BLINK_HALF_CYC = BLINK_TIME_MS * 1000 * CLK_MHZ;
	// Pause between blink groups, in half periods
	localparam logic [3:0] BLINK_GAP = 4'h4;
	// Errors per window that count as heavy disturbance
	localparam logic [15:0] HEAVY_ERR = 16'h0010;
	// Value shown at the disturbance positions while heavy
	localparam logic [15:0] HEAVY_REPORT = 16'h00FF;
	// Chain length and counter widths
	localparam int MAX_MOD = 120;
	localparam int CNT_W = 16;
	// Coupler diagnostic table positions
	localparam logic [6:0] POS_ERR_CNT = 7'h05;
	localparam logic [6:0] POS_HEAVY_A = 7'h06;
	localparam logic [6:0] POS_HEAVY_B = 7'h07;
	// Error blink codes
	localparam logic [3:0] CODE_BREAK = 4'h3;
	localparam logic [3:0] CODE_HEAVY = 4'h4;
	// Reset values
	localparam logic [15:0] CNT_RST = 16'h0000;

	typedef enum {LNK_NONE, LNK_BAD, LNK_POOR, LNK_GOOD} orl_lnk_e;

	// Increment that stops at the top instead of wrapping
	function automatic logic [15:0] orl_sat_inc(input logic [15:0] v, input logic inc);
		if (inc && v != 16'hFFFF) begin
			return v + 16'h0001;
		end
		return v;
	endfunction : orl_sat_inc

	// Whole bytes occupied by a process data width, at least one up to 248 bits, zero from 249 bits up
	function automatic logic [4:0] orl_pd_bytes(input logic [7:0] bits);
		logic [8:0] sum;
		sum = {1'b0, bits} + 9'h007;
		if (bits == 8'h00) begin
			return 5'h01;
		end
		return sum[7:3];
	endfunction : orl_pd_bytes
endpackage : orl_pkg
